/* core/stack_cpu_regs.svh */
// register offsets, widths and reset values of the stack processor data-instruction core
`ifndef STACK_CPU_REGS_SVH
`define STACK_CPU_REGS_SVH

`define CPU_DW         16
`define CPU_SW         17
`define CPU_DEPTH      32
`define CPU_PW         5
`define CPU_OPW        5

`define REG_EXEC       8'h00
`define REG_TOP        8'h04
`define REG_ADDR       8'h08
`define REG_RET        8'h0C
`define REG_PROG       8'h10
`define REG_SECOND     8'h14
`define REG_PTRS       8'h18

`define SP_RST         5'h00
`define SP1_RST        5'h01
`define WORD_RST       17'h00000
`define HSIZE_WORD     3'h2

`endif

/* core/stack_cpu_pkg.sv */
// types shared by the stack processor data-instruction core
package stack_cpu_pkg;
  `include "stack_cpu_regs.svh"

  typedef enum logic [4:0] {
    OP_NOP       = 5'h00,
    OP_LOAD_INC  = 5'h01,
    OP_LOAD_IMM  = 5'h02,
    OP_LOAD      = 5'h03,
    OP_STORE_INC = 5'h04,
    OP_STORE     = 5'h05,
    OP_ROT8      = 5'h06,
    OP_COM       = 5'h07,
    OP_SHL       = 5'h08,
    OP_SHR       = 5'h09,
    OP_MUL       = 5'h0A,
    OP_XOR       = 5'h0B,
    OP_AND       = 5'h0C,
    OP_DIV       = 5'h0D,
    OP_ADD       = 5'h0E,
    OP_POPR      = 5'h0F,
    OP_LDA       = 5'h10,
    OP_DUP       = 5'h11,
    OP_OVER      = 5'h12,
    OP_PUSHR     = 5'h13,
    OP_STA       = 5'h14,
    OP_DROP      = 5'h15
  } op_t;

  typedef enum logic [3:0] {
    T_DATA, T_S, T_ROT, T_NOT, T_SHL, T_SHR, T_XOR, T_AND,
    T_SUM, T_MUL_SUM, T_MUL_T, T_DIV_SUM, T_DIV_T, T_R, T_A
  } t_sel_t;

  typedef enum logic [2:0] {A_INC, A_MUL_SUM, A_MUL_T, A_DIV, A_T} a_sel_t;

  typedef enum logic [0:0] {R_POP, R_T} r_sel_t;
endpackage : stack_cpu_pkg

/* core/stack_cpu_data_instructions.sv */
// data-instruction execution core of a 16-bit stack processor with AHB-Lite control
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`include "stack_cpu_regs.svh"

module stack_cpu_data_instructions
  import stack_cpu_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic      [31:0]          hrdata,
  output logic      [`CPU_DW-1:0]   mem_addr,
  output logic      [`CPU_DW-1:0]   mem_wdata,
  input  wire logic [`CPU_DW-1:0]   mem_rdata,
  output logic                      mem_read,
  output logic                      mem_write
);

  logic [`CPU_SW-1:0] t;
  logic [`CPU_SW-1:0] r;
  logic [`CPU_DW-1:0] a;
  logic [`CPU_DW-1:0] p;
  logic [`CPU_PW-1:0] sp;
  logic [`CPU_PW-1:0] sp1;
  logic [`CPU_PW-1:0] rp;
  logic [`CPU_PW-1:0] rp1;
  logic [`CPU_SW-1:0] s_stack [`CPU_DEPTH];
  logic [`CPU_SW-1:0] r_stack [`CPU_DEPTH];
  logic [`CPU_SW-1:0] s;
  logic [`CPU_SW-1:0] rout;
  logic [`CPU_SW-1:0] alu_sum;
  logic [`CPU_OPW-1:0] last_op;

  // bus phase tracking
  logic               wr_ph;
  logic               rd_ph;
  logic               rd_ok;
  logic [7:0]         addr_q;
  logic               bus_wr;
  logic               go;
  op_t                op;

  // decoded controls
  logic               t_load;
  t_sel_t             t_sel;
  logic               a_load;
  a_sel_t             a_sel;
  logic               p_load;
  logic               r_load;
  r_sel_t             r_sel;
  logic               s_push;
  logic               s_pop;
  logic               r_push;
  logic               r_pop;
  logic               addr_a;
  logic [`CPU_SW-1:0] next_t;
  logic [`CPU_DW-1:0] next_a;
  logic [`CPU_SW-1:0] next_r;
  logic [31:0]        rd_mux;

  // register bus slave
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ph  <= 1'b0;
      rd_ph  <= 1'b0;
      addr_q <= 8'h00;
    end else if (ce && hready) begin
      wr_ph  <= hsel && htrans[1] && hwrite && (hsize == `HSIZE_WORD);
      rd_ph  <= hsel && htrans[1] && !hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // one wait state on reads so read data leave a flip-flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_ok  <= 1'b0;
      hrdata <= 32'h00000000;
    end else if (ce) begin
      if (rd_ph && !rd_ok) begin
        rd_ok  <= 1'b1;
        hrdata <= rd_mux;
      end else if (hready) begin
        rd_ok  <= 1'b0;
      end
    end
  end

  assign hreadyout = !(rd_ph && !rd_ok);
  assign hresp     = 1'b0;
  assign bus_wr    = ce && wr_ph;
  // an instruction executes at the edge ending its EXEC write data phase
  assign go        = bus_wr && (addr_q == `REG_EXEC);
  assign op        = go ? op_t'(hwdata[`CPU_OPW-1:0]) : OP_NOP;

  always_comb begin
    case (addr_q)
      `REG_EXEC:   rd_mux = {27'h0000000, last_op};
      `REG_TOP:    rd_mux = {15'h0000, t};
      `REG_ADDR:   rd_mux = {16'h0000, a};
      `REG_RET:    rd_mux = {15'h0000, r};
      `REG_PROG:   rd_mux = {16'h0000, p};
      `REG_SECOND: rd_mux = {15'h0000, s};
      `REG_PTRS:   rd_mux = {19'h00000, rp, 3'h0, sp};
      default:     rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      last_op <= 5'h00;
    end else if (go) begin
      last_op <= hwdata[`CPU_OPW-1:0];
    end
  end

  // datapath
  assign s       = s_stack[sp];
  assign rout    = r_stack[rp];
  assign alu_sum = {1'b0, s[`CPU_DW-1:0]} + {1'b0, t[`CPU_DW-1:0]};

  assign mem_addr  = addr_a ? a : p;
  assign mem_wdata = t[`CPU_DW-1:0];

  // decoder
  always_comb begin
    t_load    = 1'b0;
    t_sel     = T_S;
    a_load    = 1'b0;
    a_sel     = A_INC;
    p_load    = 1'b0;
    r_load    = 1'b0;
    r_sel     = R_POP;
    s_push    = 1'b0;
    s_pop     = 1'b0;
    r_push    = 1'b0;
    r_pop     = 1'b0;
    addr_a    = 1'b0;
    mem_read  = 1'b0;
    mem_write = 1'b0;
    case (op)
      OP_LOAD_INC: begin
        addr_a   = 1'b1;
        a_load   = 1'b1;
        a_sel    = A_INC;
        t_load   = 1'b1;
        t_sel    = T_DATA;
        s_push   = 1'b1;
        mem_read = 1'b1;
      end
      OP_LOAD_IMM: begin
        p_load   = 1'b1;
        t_load   = 1'b1;
        t_sel    = T_DATA;
        s_push   = 1'b1;
        mem_read = 1'b1;
      end
      OP_LOAD: begin
        addr_a   = 1'b1;
        t_load   = 1'b1;
        t_sel    = T_DATA;
        s_push   = 1'b1;
        mem_read = 1'b1;
      end
      OP_STORE_INC: begin
        addr_a    = 1'b1;
        a_load    = 1'b1;
        a_sel     = A_INC;
        t_load    = 1'b1;
        t_sel     = T_S;
        s_pop     = 1'b1;
        mem_write = 1'b1;
      end
      OP_STORE: begin
        addr_a    = 1'b1;
        t_load    = 1'b1;
        t_sel     = T_S;
        s_pop     = 1'b1;
        mem_write = 1'b1;
      end
      OP_ROT8: begin
        t_load = 1'b1;
        t_sel  = T_ROT;
      end
      OP_COM: begin
        t_load = 1'b1;
        t_sel  = T_NOT;
      end
      OP_SHL: begin
        t_load = 1'b1;
        t_sel  = T_SHL;
      end
      OP_SHR: begin
        t_load = 1'b1;
        t_sel  = T_SHR;
      end
      OP_XOR: begin
        t_load = 1'b1;
        t_sel  = T_XOR;
        s_pop  = 1'b1;
      end
      OP_AND: begin
        t_load = 1'b1;
        t_sel  = T_AND;
        s_pop  = 1'b1;
      end
      OP_ADD: begin
        t_load = 1'b1;
        t_sel  = T_SUM;
        s_pop  = 1'b1;
      end
      OP_MUL: begin
        a_load = 1'b1;
        t_load = 1'b1;
        t_sel  = a[0] ? T_MUL_SUM : T_MUL_T;
        a_sel  = a[0] ? A_MUL_SUM : A_MUL_T;
      end
      OP_DIV: begin
        a_load = 1'b1;
        t_load = 1'b1;
        a_sel  = A_DIV;
        t_sel  = alu_sum[`CPU_DW] ? T_DIV_SUM : T_DIV_T;
      end
      OP_POPR: begin
        t_load = 1'b1;
        t_sel  = T_R;
        s_push = 1'b1;
        r_sel  = R_POP;
        r_load = 1'b1;
        r_pop  = 1'b1;
      end
      OP_LDA: begin
        t_load = 1'b1;
        t_sel  = T_A;
        s_push = 1'b1;
      end
      OP_DUP: begin
        s_push = 1'b1;
      end
      OP_OVER: begin
        s_push = 1'b1;
        t_load = 1'b1;
        t_sel  = T_S;
      end
      OP_PUSHR: begin
        t_load = 1'b1;
        t_sel  = T_S;
        r_push = 1'b1;
        r_sel  = R_T;
        r_load = 1'b1;
        s_pop  = 1'b1;
      end
      OP_STA: begin
        t_load = 1'b1;
        t_sel  = T_S;
        a_sel  = A_T;
        a_load = 1'b1;
        s_pop  = 1'b1;
      end
      OP_DROP: begin
        t_load = 1'b1;
        t_sel  = T_S;
        s_pop  = 1'b1;
      end
      // nop is a slot-sequencer matter; it and unassigned codes do nothing here
      default: begin
        t_load = 1'b0;
      end
    endcase
  end

  // next-value multiplexers
  always_comb begin
    case (t_sel)
      T_DATA:    next_t = {1'b0, mem_rdata};
      T_S:       next_t = s;
      T_ROT:     next_t = {1'b0, t[7:0], t[15:8]};
      T_NOT:     next_t = ~t;
      T_SHL:     next_t = {t[15:0], 1'b0};
      T_SHR:     next_t = {1'b0, t[16:1]};
      T_XOR:     next_t = s ^ t;
      T_AND:     next_t = s & t;
      T_SUM:     next_t = alu_sum;
      T_MUL_SUM: next_t = {1'b0, alu_sum[16:1]};
      T_MUL_T:   next_t = {1'b0, t[16:1]};
      T_DIV_SUM: next_t = {alu_sum[15:0], a[15]};
      T_DIV_T:   next_t = {t[15:0], a[15]};
      T_R:       next_t = r;
      T_A:       next_t = {1'b0, a};
      default:   next_t = t;
    endcase
  end

  always_comb begin
    case (a_sel)
      A_INC:     next_a = a + 16'h0001;
      A_MUL_SUM: next_a = {alu_sum[0], a[15:1]};
      A_MUL_T:   next_a = {t[0], a[15:1]};
      A_DIV:     next_a = {a[14:0], alu_sum[16]};
      A_T:       next_a = t[`CPU_DW-1:0];
      default:   next_a = a;
    endcase
  end

  assign next_r = (r_sel == R_T) ? t : rout;

  // bus writes and execution never share an edge: one data phase at a time
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      t <= `WORD_RST;
    end else if (ce) begin
      if (t_load) begin
        t <= next_t;
      end else if (bus_wr && addr_q == `REG_TOP) begin
        t <= hwdata[`CPU_SW-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      a <= 16'h0000;
    end else if (ce) begin
      if (a_load) begin
        a <= next_a;
      end else if (bus_wr && addr_q == `REG_ADDR) begin
        a <= hwdata[`CPU_DW-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= `WORD_RST;
    end else if (ce) begin
      if (r_load) begin
        r <= next_r;
      end else if (bus_wr && addr_q == `REG_RET) begin
        r <= hwdata[`CPU_SW-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p <= 16'h0000;
    end else if (ce) begin
      if (p_load) begin
        p <= p + 16'h0001;
      end else if (bus_wr && addr_q == `REG_PROG) begin
        p <= hwdata[`CPU_DW-1:0];
      end
    end
  end

  // stack pointers: sp1 and rp1 stay one above so push needs no extra cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sp  <= `SP_RST;
      sp1 <= `SP1_RST;
    end else if (ce) begin
      if (s_push) begin
        sp  <= sp + 5'h01;
        sp1 <= sp1 + 5'h01;
      end else if (s_pop) begin
        sp  <= sp - 5'h01;
        sp1 <= sp1 - 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rp  <= `SP_RST;
      rp1 <= `SP1_RST;
    end else if (ce) begin
      if (r_push) begin
        rp  <= rp + 5'h01;
        rp1 <= rp1 + 5'h01;
      end else if (r_pop) begin
        rp  <= rp - 5'h01;
        rp1 <= rp1 - 5'h01;
      end
    end
  end

  // no overflow guard: pointers wrap, as a 32-deep circular stack
  for (genvar i = 0; i < `CPU_DEPTH; i++) begin : g_stack
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        s_stack[i] <= `WORD_RST;
        r_stack[i] <= `WORD_RST;
      end else if (ce) begin
        if (s_push && sp1 == 5'(i)) begin
          s_stack[i] <= t;
        end
        if (r_push && rp1 == 5'(i)) begin
          r_stack[i] <= r;
        end
      end
    end
  end

  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_load_addr;
    go && (op == OP_LOAD || op == OP_STORE) |-> mem_addr == a && (mem_read || mem_write);
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("load/store not at A");

  property p_load_inc;
    go && op == OP_LOAD_INC |=> a == $past(a) + 16'h0001 && t == {1'b0, $past(mem_rdata)}
      && sp == $past(sp) + 5'h01 && s == $past(t);
  endproperty
  a_load_inc: assert property (p_load_inc) else $error("load-increment wrong");

  property p_load_imm;
    go && op == OP_LOAD_IMM |-> mem_read && mem_addr == p ##1 p == $past(p) + 16'h0001;
  endproperty
  a_load_imm: assert property (p_load_imm) else $error("load-immediate wrong");

  property p_store;
    go && op == OP_STORE |-> mem_write && mem_wdata == t[15:0]
      ##1 t == $past(s) && a == $past(a) && sp == $past(sp) - 5'h01;
  endproperty
  a_store: assert property (p_store) else $error("store wrong");

  property p_rot;
    go && op == OP_ROT8 |=> t[15:0] == {$past(t[7:0]), $past(t[15:8])} && sp == $past(sp);
  endproperty
  a_rot: assert property (p_rot) else $error("byte rotate wrong");

  property p_add;
    go && op == OP_ADD |=> t == $past({1'b0, s[15:0]}) + $past({1'b0, t[15:0]});
  endproperty
  a_add: assert property (p_add) else $error("add wrong");

  property p_mul;
    go && op == OP_MUL && a[0] |=> {t, a} == 33'({$past(alu_sum), $past(a)} >> 1);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply step wrong");

  property p_div_carry;
    go && op == OP_DIV |=> a[0] == $past(alu_sum[16]) && a[15:1] == $past(a[14:0]);
  endproperty
  a_div_carry: assert property (p_div_carry) else $error("divide carry lost");

  property p_dup;
    go && op == OP_DUP |=> t == $past(t) && s == $past(t) && sp1 == sp + 5'h01;
  endproperty
  a_dup: assert property (p_dup) else $error("duplicate wrong");

  property p_unassigned;
    go && hwdata[4:0] > 5'h15 |-> !mem_read && !mem_write && !t_load && !s_push && !s_pop;
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("unassigned code acted");

  c_mul:  cover property (go && op == OP_MUL ##1 go && op == OP_MUL);
  c_div:  cover property (go && op == OP_DIV && alu_sum[16]);
  c_read: cover property (rd_ph && !rd_ok ##1 hreadyout);
  c_popr: cover property (go && op == OP_POPR);

endmodule : stack_cpu_data_instructions

/* test/word_memory_model.sv */
// word-addressed program and data memory on the far side of the core
`timescale 1ns/100ps
module word_memory_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic        mem_read,
  input  wire logic        mem_write,
  output logic      [15:0] mem_rdata
);
  logic [15:0] mem [256];
  logic [15:0] last;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {8'(i) ^ 8'hA5, 8'(i)};
    end
    last = 16'h0000;
  end

  // only 256 words: upper address bits alias
  // not read: inverse of the last word, so stale data never looks valid
  assign mem_rdata = mem_read ? mem[mem_addr[7:0]] : ~last;

  always @(posedge sys_clk) begin
    if (mem_read) begin
      last <= mem[mem_addr[7:0]];
    end
    if (mem_write) begin
      mem[mem_addr[7:0]] <= mem_wdata;
    end
  end
endmodule : word_memory_model

/* test/stack_cpu_data_instructions_tb.sv */
// self-checking bench: every data instruction run over the bus against a reference
`timescale 1ns/100ps
module stack_cpu_data_instructions_tb
  import stack_cpu_pkg::*;
();
  typedef struct {
    string       nm;
    logic [31:0] v;
  } note_t;

  logic        sys_clk;
  logic        rst;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic        mem_read;
  logic        mem_write;
  logic        rd_dp;
  logic [16:0] t;
  logic [16:0] r;
  logic [15:0] a;
  logic [15:0] p;
  logic [4:0]  sp;
  logic [4:0]  rp;
  logic [4:0]  lop;
  logic [16:0] stk [32];
  logic [16:0] rstk [32];
  logic [15:0] mv [256];
  note_t       rq [$];
  note_t       mq [$];
  int          seed = 54;
  int          n_fail = 0;
  int          n_checks = 0;

  assign hready = hreadyout;

  stack_cpu_data_instructions stack_cpu_data_instructions_i (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_read(mem_read),
    .mem_write(mem_write)
  );

  word_memory_model word_memory_model_i (
    .sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_read(mem_read), .mem_write(mem_write), .mem_rdata(mem_rdata)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
  endtask : wait_rdy

  // one single transfer; the master never assumes a latency
  task automatic bus(input logic [7:0] ad, input logic w, input logic [2:0] sz,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, ad};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= sz;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus

  task automatic rd(input logic [7:0] ad, input logic [31:0] exp, input string nm);
    rq.push_back('{nm, exp});
    bus(ad, 1'b0, 3'h2, $random(seed));
  endtask : rd

  task automatic set(input logic [7:0] ad, input logic [31:0] v);
    bus(ad, 1'b1, 3'h2, v);
    case (ad)
      8'h04: t = v[16:0];
      8'h08: a = v[15:0];
      8'h0C: r = v[16:0];
      8'h10: p = v[15:0];
      default: ;
    endcase
  endtask : set

  task automatic exec(input logic [4:0] op);
    logic [16:0] s;
    logic [16:0] sum;
    logic        pu;
    logic        po;
    s   = stk[sp];
    sum = {1'b0, s[15:0]} + {1'b0, t[15:0]};
    pu  = op inside {OP_LOAD_INC, OP_LOAD_IMM, OP_LOAD, OP_POPR, OP_LDA, OP_DUP, OP_OVER};
    po  = op inside {OP_STORE_INC, OP_STORE, OP_XOR, OP_AND, OP_ADD, OP_PUSHR, OP_STA,
                     OP_DROP};
    if (pu) begin
      stk[sp + 5'h01] = t;
    end
    case (op)
      OP_LOAD_INC, OP_LOAD: begin
        mq.push_back('{"mem read", {16'h0001, a}});
        t = {1'b0, mv[a[7:0]]};
        a = a + ((op == OP_LOAD_INC) ? 16'h0001 : 16'h0000);
      end
      OP_LOAD_IMM: begin
        mq.push_back('{"mem read", {16'h0001, p}});
        t = {1'b0, mv[p[7:0]]};
        p = p + 16'h0001;
      end
      OP_STORE_INC, OP_STORE: begin
        mq.push_back('{"mem write", {t[15:0], a}});
        mv[a[7:0]] = t[15:0];
        a = a + ((op == OP_STORE_INC) ? 16'h0001 : 16'h0000);
        t = s;
      end
      OP_ROT8: t = {1'b0, t[7:0], t[15:8]};
      OP_COM: t = ~t;
      OP_SHL: t = {t[15:0], 1'b0};
      OP_SHR: t = {1'b0, t[16:1]};
      OP_MUL: {t, a} = a[0] ? {sum, a} >> 1 : {t, a} >> 1;
      OP_XOR: t = s ^ t;
      OP_AND: t = s & t;
      OP_DIV: {t, a} = {sum[16] ? sum[15:0] : t[15:0], a, sum[16]};
      OP_ADD: t = sum;
      OP_POPR: begin
        t  = r;
        r  = rstk[rp];
        rp = rp - 5'h01;
      end
      OP_LDA: t = {1'b0, a};
      OP_OVER: t = s;
      OP_PUSHR: begin
        rstk[rp + 5'h01] = r;
        rp = rp + 5'h01;
        r  = t;
        t  = s;
      end
      OP_STA: begin
        a = t[15:0];
        t = s;
      end
      OP_DROP: t = s;
      default: ;
    endcase
    if (pu) begin
      sp = sp + 5'h01;
    end else if (po) begin
      sp = sp - 5'h01;
    end
    lop = op;
    bus(8'h00, 1'b1, 3'h2, {27'h0, op});
  endtask : exec

  task automatic verify;
    rd(8'h00, {27'h0, lop}, "last opcode");
    rd(8'h04, {15'h0, t}, "T");
    rd(8'h08, {16'h0, a}, "A");
    rd(8'h0C, {15'h0, r}, "R");
    rd(8'h10, {16'h0, p}, "P");
    rd(8'h14, {15'h0, stk[sp]}, "second");
    rd(8'h18, {19'h0, rp, 3'h0, sp}, "pointers");
  endtask : verify

  task automatic rnd_regs;
    for (int i = 1; i < 5; i++) begin
      set(8'(4 * i), $random(seed));
    end
  endtask : rnd_regs

  // results are judged here, in the order the driver noted them
  always @(posedge sys_clk) begin
    note_t e;
    if (rd_dp && hready) begin
      e = rq.pop_front();
      check(e.nm, hrdata, e.v);
      check("hresp", {31'h0, hresp}, 32'h0);
    end
    if (mem_read === 1'b1 || mem_write === 1'b1) begin
      e = mq.pop_front();
      check(e.nm, {mem_write ? mem_wdata : {15'h0, mem_read}, mem_addr}, e.v);
    end
    if (rst) begin
      rd_dp <= 1'b0;
    end else if (hready) begin
      rd_dp <= hsel && htrans[1] && !hwrite;
    end
  end

  initial begin
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] d;
    logic [31:0] dvd;
    rst    = 1'b1;
    ce     = 1'b1;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    {t, r, a, p, sp, rp, lop} = '0;
    for (int i = 0; i < 32; i++) begin
      stk[i]  = 17'h0;
      rstk[i] = 17'h0;
    end
    for (int i = 0; i < 256; i++) begin
      mv[i] = {8'(i) ^ 8'hA5, 8'(i)};
    end
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    verify();
    $display("test reset done");
    // byte-size, read-only and unmapped writes must all leave state alone
    bus(8'h04, 1'b1, 3'h0, 32'h0001FFFF);
    set(8'h14, $random(seed));
    set(8'h18, $random(seed));
    set(8'h20, $random(seed));
    rd(8'h1C, 32'h0, "unmapped");
    // frozen core: a write and a load while ce is low must leave no trace
    ce <= 1'b0;
    bus(8'h04, 1'b1, 3'h2, $random(seed));
    bus(8'h00, 1'b1, 3'h2, {27'h0, OP_LOAD_INC});
    ce <= 1'b1;
    verify();
    $display("test refusals done");
    rnd_regs();
    for (int i = 0; i < 32; i++) begin
      exec(5'(i));
      verify();
    end
    $display("test opcode sweep done");
    for (int i = 0; i < 120; i++) begin
      if (i % 6 == 0) begin
        rnd_regs();
      end
      exec(5'($random(seed)));
      verify();
    end
    $display("test random programs done");
    exec(OP_LOAD_INC);
    exec(OP_LOAD_IMM);
    exec(OP_STORE_INC);
    exec(OP_STORE);
    exec(OP_LOAD);
    verify();
    $display("test back to back done");
    repeat (33) exec(OP_DUP);
    verify();
    repeat (33) exec(OP_DROP);
    verify();
    $display("test stack wrap done");
    x = 16'($random(seed));
    y = 16'($random(seed));
    set(8'h04, {16'h0, x});
    exec(OP_DUP);
    set(8'h04, 32'h0);
    set(8'h08, {16'h0, y});
    repeat (16) exec(OP_MUL);
    dvd = {16'h0, x} * {16'h0, y};
    rd(8'h04, {16'h0, dvd[31:16]}, "product high");
    rd(8'h08, {16'h0, dvd[15:0]}, "product low");
    $display("test multiply done");
    // divisor below 2^15 keeps twice the remainder inside the adder's 16 bits
    d = {2'b01, 14'($random(seed))};
    set(8'h04, {16'h0, ~d + 16'h0001});
    exec(OP_DUP);
    x = {2'b00, 14'($random(seed))};
    y = 16'($random(seed));
    set(8'h04, {16'h0, x});
    set(8'h08, {16'h0, y});
    repeat (17) exec(OP_DIV);
    dvd = {x, y};
    rd(8'h08, dvd / {16'h0, d}, "quotient");
    rd(8'h04, (dvd % {16'h0, d}) << 1, "twice remainder");
    verify();
    $display("test divide done");
    check("memory notes left", 32'(mq.size()), 32'h0);
    end_sim();
  end
endmodule : stack_cpu_data_instructions_tb
